//--- rtl/ocdd_pkg.sv
package ocdd_pkg;

    // Outputs and field widths
    localparam int unsigned OCDD_NUM_OUT    = 8;
    localparam int unsigned OCDD_CNT_W      = 4;
    localparam int unsigned OCDD_REG_W      = 8;
    localparam int unsigned OCDD_RATIO_W    = 6;

    // Register indexes; byte address is the index times four
    localparam logic [7:0]  OCDD_IDX_OUT0    = 8'h48;
    localparam logic [7:0]  OCDD_IDX_OUT7    = 8'h56;
    localparam logic [7:0]  OCDD_IDX_BYPASS  = 8'h5a;
    localparam logic [7:0]  OCDD_IDX_RESTART = 8'h5b;
    localparam logic [7:0]  OCDD_IDX_STATUS  = 8'h5c;
    localparam int unsigned OCDD_IDX_SHIFT   = 2;

    // Field positions inside a count byte
    localparam int unsigned OCDD_HI_LSB     = 0;
    localparam int unsigned OCDD_LO_LSB     = 4;

    // Field positions inside the status word
    localparam int unsigned OCDD_ST_LVL_LSB = 0;
    localparam int unsigned OCDD_ST_RUN_LSB = 8;

    // Reset values
    localparam logic [7:0]  OCDD_CNT_RST    = 8'h00;
    localparam logic [7:0]  OCDD_BYPASS_RST = 8'h00;

    // Divider states
    typedef enum logic [2:0] {
        OCDD_ST_OFF  = 3'b001,
        OCDD_ST_HIGH = 3'b010,
        OCDD_ST_LOW  = 3'b100
    } ocdd_state_e;

endpackage : ocdd_pkg

//--- rtl/ocdd_div_if.sv
`timescale 1ns/1ns
// Settings into one divider and its state back out
interface ocdd_div_if;
    logic [3:0] high_cnt;
    logic [3:0] low_cnt;
    logic       bypass;
    logic       restart;
    logic       level;
    logic       running;

    modport ctl (output high_cnt, output low_cnt, output bypass, output restart,
                 input level, input running);
    modport div (input high_cnt, input low_cnt, input bypass, input restart,
                 output level, output running);
endinterface : ocdd_div_if

//--- rtl/ocdd_divider.sv
`timescale 1ns/1ns
// One output divider; counts are taken at the start of each period
module ocdd_divider (
    input  wire logic pclk,
    input  wire logic presetn,
    ocdd_div_if.div   dif
);

    ocdd_pkg::ocdd_state_e state_q, state_d;
    logic [3:0]            cnt_q,   cnt_d;
    logic [3:0]            hi_q,    hi_d;
    logic [3:0]            lo_q,    lo_d;
    logic                  quiet;

    assign quiet = !dif.bypass && !dif.restart;

    // Next state: high phase, then low phase, then reload counts
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        hi_d    = hi_q;
        lo_d    = lo_q;
        case (state_q)
            ocdd_pkg::OCDD_ST_OFF: begin
                state_d = ocdd_pkg::OCDD_ST_HIGH;
                cnt_d   = 4'h0;
                hi_d    = dif.high_cnt;
                lo_d    = dif.low_cnt;
            end
            ocdd_pkg::OCDD_ST_HIGH: begin
                if (cnt_q == hi_q) begin
                    state_d = ocdd_pkg::OCDD_ST_LOW;
                    cnt_d   = 4'h0;
                end else begin
                    cnt_d = cnt_q + 4'h1;
                end
            end
            ocdd_pkg::OCDD_ST_LOW: begin
                if (cnt_q == lo_q) begin
                    state_d = ocdd_pkg::OCDD_ST_HIGH;
                    cnt_d   = 4'h0;
                    hi_d    = dif.high_cnt;
                    lo_d    = dif.low_cnt;
                end else begin
                    cnt_d = cnt_q + 4'h1;
                end
            end
            default: begin
                state_d = ocdd_pkg::OCDD_ST_OFF;
            end
        endcase
        // Bypass powers the divider down; restart realigns it
        if (!quiet) begin
            state_d = ocdd_pkg::OCDD_ST_OFF;
            cnt_d   = 4'h0;
        end
    end

    // State registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ocdd_pkg::OCDD_ST_OFF;
            cnt_q   <= 4'h0;
            hi_q    <= 4'h0;
            lo_q    <= 4'h0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            hi_q    <= hi_d;
            lo_q    <= lo_d;
        end
    end

    assign dif.level   = (state_q == ocdd_pkg::OCDD_ST_HIGH);
    assign dif.running = (state_q != ocdd_pkg::OCDD_ST_OFF);

    // Helper: cycles spent in the current state
    logic [4:0] run_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 5'h00;
        end else if (state_d != state_q) begin
            run_q <= 5'h00;
        end else begin
            run_q <= run_q + 5'h01;
        end
    end

    sequence s_quiet;
        !dif.bypass && !dif.restart;
    endsequence

    property p_high_len;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ocdd_pkg::OCDD_ST_HIGH && state_d == ocdd_pkg::OCDD_ST_LOW)
            |-> (run_q == {1'b0, hi_q});
    endproperty
    a_high_len: assert property (p_high_len) else $error("High phase length wrong");

    property p_low_len;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ocdd_pkg::OCDD_ST_LOW && state_d == ocdd_pkg::OCDD_ST_HIGH)
            |-> (run_q == {1'b0, lo_q});
    endproperty
    a_low_len: assert property (p_low_len) else $error("Low phase length wrong");

    property p_div2;
        @(posedge pclk) disable iff (!presetn)
        ($rose(dif.level) && hi_q == 4'h0 && lo_q == 4'h0 && quiet) ##1 s_quiet
            |-> !dif.level ##1 dif.level;
    endproperty
    a_div2: assert property (p_div2) else $error("Divide by two not half duty");

    property p_div4_75;
        @(posedge pclk) disable iff (!presetn)
        ($rose(dif.level) && hi_q == 4'h2 && lo_q == 4'h0 && quiet) ##1 s_quiet[*3]
            |-> $past(dif.level, 2) && $past(dif.level) && !dif.level ##1 dif.level;
    endproperty
    a_div4_75: assert property (p_div4_75) else $error("Divide by four 75 percent wrong");

    property p_bypass_off;
        @(posedge pclk) disable iff (!presetn)
        dif.bypass |=> !dif.level && !dif.running;
    endproperty
    a_bypass_off: assert property (p_bypass_off) else $error("Bypassed divider still runs");

endmodule : ocdd_divider

//--- rtl/ocdd_top.sv
// Added by the designer: the APB slave port.
`timescale 1ns/1ns
// Eight output dividers with their APB register file
module ocdd_top #(
    parameter int unsigned ADDR_W  = 12,
    parameter logic [7:0]  CNT_RST = ocdd_pkg::OCDD_CNT_RST
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic      [7:0]        out_level,
    output logic      [7:0]        out_bypass
);

    localparam int unsigned NOUT = ocdd_pkg::OCDD_NUM_OUT;
    localparam int unsigned WW   = ADDR_W - ocdd_pkg::OCDD_IDX_SHIFT;

    // Decode result of one address
    typedef struct packed {
        logic       out_hit;
        logic [2:0] out_sel;
        logic       byp_hit;
        logic       rst_hit;
        logic       sts_hit;
    } ocdd_dec_s;

    // Address decode, shared by the setup and access phases
    function automatic ocdd_dec_s ocdd_decode(input logic [ADDR_W-1:0] addr);
        ocdd_dec_s   d;
        logic [WW-1:0] word;
        logic [WW-1:0] rel;
        d    = '0;
        word = addr[ADDR_W-1:ocdd_pkg::OCDD_IDX_SHIFT];
        rel  = word - WW'(ocdd_pkg::OCDD_IDX_OUT0);
        if (addr[1:0] != 2'b00) begin
            d = '0;
        end else if (word >= WW'(ocdd_pkg::OCDD_IDX_OUT0)
                     && word <= WW'(ocdd_pkg::OCDD_IDX_OUT7) && !word[0]) begin
            d.out_hit = 1'b1;
            d.out_sel = rel[3:1];
        end else if (word == WW'(ocdd_pkg::OCDD_IDX_BYPASS)) begin
            d.byp_hit = 1'b1;
        end else if (word == WW'(ocdd_pkg::OCDD_IDX_RESTART)) begin
            d.rst_hit = 1'b1;
        end else if (word == WW'(ocdd_pkg::OCDD_IDX_STATUS)) begin
            d.sts_hit = 1'b1;
        end
        return d;
    endfunction : ocdd_decode

    // Divide ratio of one count byte
    function automatic logic [5:0] ocdd_ratio(input logic [7:0] cfg);
        logic [5:0] hi;
        logic [5:0] lo;
        hi = {2'b00, cfg[ocdd_pkg::OCDD_HI_LSB +: ocdd_pkg::OCDD_CNT_W]};
        lo = {2'b00, cfg[ocdd_pkg::OCDD_LO_LSB +: ocdd_pkg::OCDD_CNT_W]};
        return hi + lo + 6'h02;
    endfunction : ocdd_ratio

    ocdd_dec_s  dec;
    logic       setup;
    logic       wr_en;
    logic       bad;
    logic [7:0] level;
    logic [7:0] running;

    assign dec   = ocdd_decode(paddr);
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite;
    assign bad   = !(dec.out_hit || dec.byp_hit || dec.rst_hit || dec.sts_hit)
                   || (pwrite && dec.sts_hit);

    // Register state
    logic [7:0]  cnt_q     [NOUT];
    logic [7:0]  cnt_d     [NOUT];
    logic [7:0]  bypass_q,  bypass_d;
    logic [7:0]  restart_q, restart_d;
    logic [31:0] prdata_q,  prdata_d;
    logic        err_q,     err_d;
    logic [31:0] rd_mux;
    logic [8*NOUT-1:0] cnt_flat;

    // Read data for the addressed register
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (dec.out_hit) begin
            rd_mux[7:0] = cnt_q[dec.out_sel];
        end else if (dec.byp_hit) begin
            rd_mux[7:0] = bypass_q;
        end else if (dec.sts_hit) begin
            rd_mux[ocdd_pkg::OCDD_ST_LVL_LSB +: 8] = level;
            rd_mux[ocdd_pkg::OCDD_ST_RUN_LSB +: 8] = running;
        end
    end

    // Next register values: read data caught in setup, writes in access
    always_comb begin
        for (int i = 0; i < NOUT; i++) begin
            cnt_d[i] = cnt_q[i];
        end
        bypass_d  = bypass_q;
        restart_d = 8'h00;
        prdata_d  = prdata_q;
        err_d     = err_q;
        if (setup) begin
            prdata_d = pwrite ? 32'h0000_0000 : rd_mux;
            err_d    = bad;
        end
        if (wr_en && dec.out_hit) begin
            cnt_d[dec.out_sel] = pwdata[7:0];
        end else if (wr_en && dec.byp_hit) begin
            bypass_d = pwdata[7:0];
        end else if (wr_en && dec.rst_hit) begin
            restart_d = pwdata[7:0];
        end
    end

    // Register file flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NOUT; i++) begin
                cnt_q[i] <= CNT_RST;
            end
            bypass_q  <= ocdd_pkg::OCDD_BYPASS_RST;
            restart_q <= 8'h00;
            prdata_q  <= 32'h0000_0000;
            err_q     <= 1'b0;
        end else begin
            for (int i = 0; i < NOUT; i++) begin
                cnt_q[i] <= cnt_d[i];
            end
            bypass_q  <= bypass_d;
            restart_q <= restart_d;
            prdata_q  <= prdata_d;
            err_q     <= err_d;
        end
    end

    // Zero wait states; pslverr stands only in the access phase, prdata holds until the next setup
    assign pready  = 1'b1;
    assign prdata  = prdata_q;
    assign pslverr = psel && penable && err_q;

    // One divider per output, fed from its count byte
    ocdd_div_if div_if [NOUT] ();

    for (genvar g = 0; g < NOUT; g++) begin : g_out
        assign div_if[g].high_cnt = cnt_q[g][ocdd_pkg::OCDD_HI_LSB +: 4];
        assign div_if[g].low_cnt  = cnt_q[g][ocdd_pkg::OCDD_LO_LSB +: 4];
        assign div_if[g].bypass   = bypass_q[g];
        assign div_if[g].restart  = restart_q[g];
        assign level[g]           = div_if[g].level;
        assign running[g]         = div_if[g].running;
        assign cnt_flat[g*8 +: 8] = cnt_q[g];

        ocdd_divider u_div (
            .pclk    (pclk),
            .presetn (presetn),
            .dif     (div_if[g])
        );
    end

    // Divider levels and bypass flags to the output stage
    assign out_level  = level;
    assign out_bypass = bypass_q;

    // Helper: period of output 0 measured rise to rise
    logic [5:0] per_q;
    logic       per_ok_q;
    logic [7:0] cfg0_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_q    <= 6'h00;
            per_ok_q <= 1'b0;
            cfg0_q   <= 8'h00;
        end else if (restart_q[0] || bypass_q[0] || cnt_q[0] != cfg0_q) begin
            per_q    <= 6'h00;
            per_ok_q <= 1'b0;
            cfg0_q   <= cnt_q[0];
        end else if ($rose(level[0])) begin
            per_q    <= 6'h01;
            per_ok_q <= 1'b1;
            cfg0_q   <= cnt_q[0];
        end else begin
            per_q    <= per_q + 6'h01;
            per_ok_q <= per_ok_q;
            cfg0_q   <= cfg0_q;
        end
    end

    sequence s_setup_rd;
        psel && !penable && !pwrite;
    endsequence

    property p_ratio;
        @(posedge pclk) disable iff (!presetn)
        ($rose(level[0]) && per_ok_q && cnt_q[0] == cfg0_q && !bypass_q[0])
            |-> per_q == ocdd_ratio(cfg0_q);
    endproperty
    a_ratio: assert property (p_ratio) else $error("Output 0 period wrong");

    property p_wr_fields;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && dec.out_hit && dec.out_sel == 3'h0)
            |=> div_if[0].low_cnt == $past(pwdata[7:4])
                && div_if[0].high_cnt == $past(pwdata[3:0]);
    endproperty
    a_wr_fields: assert property (p_wr_fields) else $error("Count fields misplaced");

    property p_rd_cnt;
        @(posedge pclk) disable iff (!presetn)
        (s_setup_rd and (dec.out_hit && dec.out_sel == 3'h7 && cnt_q[7] == cnt_d[7]))
            |=> prdata == {24'h00_0000, cnt_q[7]};
    endproperty
    a_rd_cnt: assert property (p_rd_cnt) else $error("Count readback wrong");

    property p_unmapped;
        @(posedge pclk) disable iff (!presetn)
        (setup && bad) |=> (penable && psel) |-> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("Unmapped access not flagged");

    property p_bypass_low;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && dec.byp_hit && pwdata[0]) |=> out_bypass[0] ##1 !out_level[0];
    endproperty
    a_bypass_low: assert property (p_bypass_low) else $error("Bypass did not stop output");

    // Bypass register takes the written byte whole
    property p_wr_bypass;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && dec.byp_hit) |=> out_bypass == $past(pwdata[7:0]);
    endproperty
    a_wr_bypass: assert property (p_wr_bypass) else $error("Bypass write lost");

    // Any count byte takes any value of both fields
    property p_wr_cnt_any;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && dec.out_hit)
            |=> cnt_q[$past(dec.out_sel)] == $past(pwdata[7:0]);
    endproperty
    a_wr_cnt_any: assert property (p_wr_cnt_any) else $error("Count write lost");

    // Refused writes leave every register alone
    property p_refused_hold;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && bad) |=> $stable(cnt_flat) && $stable(bypass_q) && restart_q == 8'h00;
    endproperty
    a_refused_hold: assert property (p_refused_hold) else $error("Refused write changed state");

    // Status read reports levels and which dividers run
    property p_rd_status;
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && dec.sts_hit)
            |=> prdata[15:8] == $past(running) && prdata[31:16] == 16'h0000
                && prdata[7:0] == $past(level);
    endproperty
    a_rd_status: assert property (p_rd_status) else $error("Status readback wrong");

    // Bypass byte reads back as written
    property p_rd_bypass;
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && dec.byp_hit) |=> prdata == {24'h00_0000, $past(bypass_q)};
    endproperty
    a_rd_bypass: assert property (p_rd_bypass) else $error("Bypass readback wrong");

    // Restart: one quiet cycle on output 7, then high again
    sequence s_realign7;
        !out_level[7] ##1 out_level[7];
    endsequence

    property p_restart7;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && dec.rst_hit && pwdata[7] && !bypass_q[7]) |=> ##1 s_realign7;
    endproperty
    a_restart7: assert property (p_restart7) else $error("Restart did not realign");

    // Write and refused setups leave no read data behind
    property p_wr_rdata;
        @(posedge pclk) disable iff (!presetn)
        (setup && (pwrite || bad)) |=> prdata == 32'h0000_0000;
    endproperty
    a_wr_rdata: assert property (p_wr_rdata) else $error("Stale read data");

    // A bypassed output is held low from the next cycle on
    property p_bypass_all;
        @(posedge pclk) disable iff (!presetn)
        (out_level & $past(bypass_q)) == 8'h00;
    endproperty
    a_bypass_all: assert property (p_bypass_all) else $error("Bypassed output toggles");

    // Mapped accesses other than status writes finish without error
    property p_ok_no_err;
        @(posedge pclk) disable iff (!presetn)
        (setup && !bad) |=> (penable && psel) |-> !pslverr;
    endproperty
    a_ok_no_err: assert property (p_ok_no_err) else $error("Mapped access flagged");

endmodule : ocdd_top

//--- sim/ocdd_sink.sv
`timescale 1ns/1ns
// Downstream clock load: measures every finished high and low stretch of each output; stretches over 63 samples read as 63
module ocdd_sink (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [7:0] level,
    output logic      [5:0] hi_run [8],
    output logic      [5:0] lo_run [8]
);
    logic [5:0] run_q [8];
    logic [7:0] prev_q;

    // Count samples at one level; store the count when the level flips
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= 8'h00;
            for (int i = 0; i < 8; i++) begin
                run_q[i]  <= 6'h00;
                hi_run[i] <= 6'h00;
                lo_run[i] <= 6'h00;
            end
        end else begin
            prev_q <= level;
            for (int i = 0; i < 8; i++) begin
                if (level[i] != prev_q[i]) begin
                    run_q[i] <= 6'h01;
                    if (prev_q[i]) begin
                        hi_run[i] <= run_q[i];
                    end else begin
                        lo_run[i] <= run_q[i];
                    end
                end else if (run_q[i] != 6'h3f) begin
                    run_q[i] <= run_q[i] + 6'h01;  // Saturate on long idle stretches
                end
            end
        end
    end
endmodule : ocdd_sink

//--- sim/ocdd_tb_top.sv
`timescale 1ns/1ns
// Bench for the eight output dividers and their register file
module ocdd_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0]  out_level, out_bypass;
    logic [5:0]  hi_run [8];
    logic [5:0]  lo_run [8];
    int          bad_count;
    int          total_checks;

    ocdd_top #(.ADDR_W(12)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .out_level(out_level), .out_bypass(out_bypass)
    );

    ocdd_sink sink_u (
        .pclk(pclk), .presetn(presetn), .level(out_level), .hi_run(hi_run), .lo_run(lo_run)
    );

    // Clock, 20 ns period
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // Print the counts and the verdict, then stop
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    // Compare one value
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One APB transfer: setup, then access until pready at a rising edge
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
            if (n > 50) begin
                bad_count++;
                wrap_up();
            end
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Byte address of the count byte of output n
    function automatic logic [11:0] cnt_addr(input int n);
        return 12'((ocdd_pkg::OCDD_IDX_OUT0 + 2 * n) << ocdd_pkg::OCDD_IDX_SHIFT);
    endfunction : cnt_addr

    // Reset values of the count bytes and the default divide by two
    task automatic t_reset();
        logic [31:0] rd;
        logic        err;
        apb(1'b0, cnt_addr(0), 32'h0, rd, err);
        chk("out0 reset", 32'h00000000, rd);
        apb(1'b0, cnt_addr(7), 32'h0, rd, err);
        chk("out7 reset", 32'h00000000, rd);
        repeat (10) @(posedge pclk);
        chk("div2 high", 32'h1, {26'h0, hi_run[3]});
        chk("div2 low", 32'h1, {26'h0, lo_run[3]});
        $display("test reset done");
    endtask : t_reset

    // Field layout, full range of both counts, and the resulting waveforms
    task automatic t_fields();
        logic [7:0]  cfg [8] = '{8'h00, 8'h02, 8'h20, 8'h11, 8'h5a, 8'hf0, 8'h0f, 8'hff};
        logic [31:0] rd;
        logic        err;
        for (int n = 0; n < 8; n++) begin
            apb(1'b1, cnt_addr(n), {24'hffffff, cfg[n]}, rd, err);
            chk("write err", 32'h0, {31'h0, err});
        end
        for (int n = 0; n < 8; n++) begin
            apb(1'b0, cnt_addr(n), 32'h0, rd, err);
            chk("readback", {24'h0, cfg[n]}, rd);
        end
        repeat (100) @(posedge pclk);
        for (int n = 0; n < 8; n++) begin
            chk("high run", 32'(cfg[n][3:0]) + 1, {26'h0, hi_run[n]});
            chk("low run", 32'(cfg[n][7:4]) + 1, {26'h0, lo_run[n]});
            chk("ratio", 32'(cfg[n][3:0]) + 32'(cfg[n][7:4]) + 2,
                32'(hi_run[n]) + 32'(lo_run[n]));
        end
        $display("test fields done");
    endtask : t_fields

    // Divide by one only through bypass; the divider itself stays quiet
    task automatic t_bypass();
        logic [31:0] rd;
        logic        err;
        logic        seen;
        apb(1'b1, 12'(ocdd_pkg::OCDD_IDX_BYPASS) << 2, 32'h00000001, rd, err);
        repeat (3) @(posedge pclk);
        seen = 1'b0;
        repeat (40) begin
            @(posedge pclk);
            seen = seen | out_level[0];
        end
        chk("bypass flags", 32'h01, {24'h0, out_bypass});
        chk("bypassed level", 32'h0, {31'h0, seen});
        apb(1'b0, 12'(ocdd_pkg::OCDD_IDX_STATUS) << 2, 32'h0, rd, err);
        chk("status running", 32'hfe, {8'h00, rd[31:8]});
        chk("status level0", 32'h0, {31'h0, rd[0]});
        apb(1'b1, 12'(ocdd_pkg::OCDD_IDX_BYPASS) << 2, 32'h0, rd, err);
        repeat (10) @(posedge pclk);
        chk("bypass cleared", 32'h0, {24'h0, out_bypass});
        chk("div2 again high", 32'h1, {26'h0, hi_run[0]});
        chk("div2 again low", 32'h1, {26'h0, lo_run[0]});
        $display("test bypass done");
    endtask : t_bypass

    // Restart realigns output 7: one quiet cycle, then a full high stretch
    task automatic t_restart();
        logic [31:0] rd;
        logic        err;
        int          ones;
        apb(1'b1, 12'(ocdd_pkg::OCDD_IDX_RESTART) << 2, 32'h00000080, rd, err);
        repeat (2) @(posedge pclk);
        chk("restart quiet", 32'h0, {31'h0, out_level[7]});
        ones = 0;
        repeat (20) begin
            @(posedge pclk);
            ones += out_level[7];
        end
        chk("restart high run", 32'h10, 32'(ones));
        apb(1'b0, 12'(ocdd_pkg::OCDD_IDX_RESTART) << 2, 32'h0, rd, err);
        chk("restart reads zero", 32'h0, rd);
        $display("test restart done");
    endtask : t_restart

    // Reset in mid-run brings back the reset values of every register
    task automatic t_midreset();
        logic [31:0] rd;
        logic        err;
        apb(1'b1, 12'(ocdd_pkg::OCDD_IDX_BYPASS) << 2, 32'h00000002, rd, err);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk("reset bypass", 32'h0, {24'h0, out_bypass});
        apb(1'b0, cnt_addr(2), 32'h0, rd, err);
        chk("count after reset", 32'h0, rd);
        apb(1'b0, 12'(ocdd_pkg::OCDD_IDX_BYPASS) << 2, 32'h0, rd, err);
        chk("bypass after reset", 32'h0, rd);
        repeat (10) @(posedge pclk);
        chk("reset div2 high", 32'h1, {26'h0, hi_run[7]});
        chk("reset div2 low", 32'h1, {26'h0, lo_run[7]});
        $display("test midreset done");
    endtask : t_midreset

    // Unmapped, odd-index, unaligned and read-only places are refused
    task automatic t_refuse();
        logic [11:0] bad [4] = '{12'h000, 12'h124, 12'h121, 12'h170};
        logic [31:0] rd;
        logic        err;
        for (int i = 0; i < 4; i++) begin
            apb(i == 3, bad[i], 32'h000000ff, rd, err);
            chk("refused", 32'h1, {31'h0, err});
        end
        apb(1'b0, cnt_addr(2), 32'h0, rd, err);
        chk("untouched", 32'h20, rd);
        $display("test refuse done");
    endtask : t_refuse

    // Main sequence
    initial begin
        bad_count    = 0;
        total_checks = 0;
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h00000000;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_fields();
        t_refuse();
        t_bypass();
        t_restart();
        t_midreset();
        wrap_up();
    end
endmodule : ocdd_tb_top
